// ===== hdl/wct_top.v
// Wake-up criteria and self-polling timeout register bank with APB slave
`timescale 1ns/1ps
`include "wct_defines.vh"

module wct_top #(
    parameter OBS_CYC  = `WCT_OBS_CYC,
    parameter SYNC_CYC = `WCT_SYNC_CYC
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [9:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  rssi_level,
    input  wire        chan_sel,
    input  wire        sig_rec,
    input  wire        t16_strobe,
    input  wire [7:0]  peak_in,
    input  wire        obs_start,
    input  wire        search_start,
    input  wire        sync_found,
    input  wire        cycle_start,
    input  wire        rmsp_active,
    output reg         wake_up,
    output reg         fallback_event,
    output reg  [7:0]  peak_sat,
    output reg         obs_done,
    output reg         search_expired,
    output reg         return_self_poll,
    output reg         irq
);

// ----------------------------------------
// Register storage
// ----------------------------------------
reg  [7:0] th_reg [0:1];
reg  [7:0] bl_reg [0:1];
reg  [7:0] bh_reg [0:1];
reg  [7:0] sat_reg;
reg  [7:0] lot_reg;
reg  [7:0] src_reg;
reg  [7:0] tos_reg;
reg  [4:0] stat_reg;
reg  [4:0] mask_reg;
reg  [2:0] ctrl_reg;

wire [7:0] idx     = paddr[9:2];
wire       acc     = psel & penable;
wire       wr_en   = acc & pready & pwrite & ~pslverr;
wire [7:0] wdat    = pwdata[7:0];
reg        hit_map;
reg  [7:0] rd_val;

// ----------------------------------------
// APB decode and read mux
// ----------------------------------------
always @*
begin
    hit_map = 1'b1;
    rd_val  = 8'h00;
    case (idx)
        `WCT_IDX_TH2:  rd_val = th_reg[0];
        `WCT_IDX_BL2:  rd_val = bl_reg[0];
        `WCT_IDX_BH2:  rd_val = bh_reg[0];
        `WCT_IDX_TH3:  rd_val = th_reg[1];
        `WCT_IDX_BL3:  rd_val = bl_reg[1];
        `WCT_IDX_BH3:  rd_val = bh_reg[1];
        `WCT_IDX_SAT:  rd_val = sat_reg;
        `WCT_IDX_LOT:  rd_val = lot_reg;
        `WCT_IDX_SRC:  rd_val = src_reg;
        `WCT_IDX_TOS:  rd_val = tos_reg;
        `WCT_IDX_STAT: rd_val = {3'h0, stat_reg};
        `WCT_IDX_MASK: rd_val = {3'h0, mask_reg};
        `WCT_IDX_CTRL: rd_val = {5'h0, ctrl_reg};
        default:       hit_map = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00)
        hit_map = 1'b0;
end

// One wait state: the answer is prepared while pready is low
always @(posedge mclk)
begin
    if (rst)
    begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end
    else if (acc & ~pready)
    begin
        pready  <= 1'b1;
        pslverr <= ~hit_map;
        prdata  <= (hit_map & ~pwrite) ? {24'h0000_00, rd_val} : 32'h0000_0000;
    end
    else
    begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
    end
end

// ----------------------------------------
// Per-channel settings and RSSI compare
// ----------------------------------------
wire [1:0] rssi_hit;

genvar c;
generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_chan
        wire [7:0] i_th = c ? `WCT_IDX_TH3 : `WCT_IDX_TH2;
        wire [7:0] i_bl = c ? `WCT_IDX_BL3 : `WCT_IDX_BL2;
        wire [7:0] i_bh = c ? `WCT_IDX_BH3 : `WCT_IDX_BH2;

        always @(posedge mclk)
        begin
            if (rst)
                th_reg[c] <= `WCT_RST_TH;
            else if (wr_en && idx == i_th)
                th_reg[c] <= wdat;
        end

        always @(posedge mclk)
        begin
            if (rst)
                bl_reg[c] <= `WCT_RST_BL;
            else if (wr_en && idx == i_bl)
                bl_reg[c] <= wdat;
        end

        always @(posedge mclk)
        begin
            if (rst)
                bh_reg[c] <= `WCT_RST_BH;
            else if (wr_en && idx == i_bh)
                bh_reg[c] <= wdat;
        end

        assign rssi_hit[c] = (rssi_level > th_reg[c]) &&
                             (rssi_level <= bl_reg[c]) &&
                             (rssi_level >= bh_reg[c]);
    end
endgenerate

// ----------------------------------------
// Shared settings, mask and control
// ----------------------------------------
always @(posedge mclk)
begin
    if (rst)
    begin
        sat_reg  <= `WCT_RST_SAT;
        lot_reg  <= `WCT_RST_LOT;
        src_reg  <= `WCT_RST_SRC;
        tos_reg  <= `WCT_RST_TOS;
        mask_reg <= `WCT_RST_MASK;
        ctrl_reg <= `WCT_RST_CTRL;
    end
    else if (wr_en)
    begin
        if (idx == `WCT_IDX_SAT)
            sat_reg <= wdat;
        if (idx == `WCT_IDX_LOT)
            lot_reg <= wdat;
        if (idx == `WCT_IDX_SRC)
            src_reg <= wdat;
        if (idx == `WCT_IDX_TOS)
            tos_reg <= wdat;
        if (idx == `WCT_IDX_MASK)
            mask_reg <= wdat[4:0];
        if (idx == `WCT_IDX_CTRL)
            ctrl_reg <= wdat[2:0];
    end
end

// ----------------------------------------
// Wake-up criterion evaluation
// ----------------------------------------
wire       crit_sr = ctrl_reg[chan_sel];
wire [7:0] bh_act  = bh_reg[chan_sel];
wire [7:0] sr_tgt  = (bh_act == 8'h00) ? 8'h01 : bh_act;
reg        hit_prev_reg;
reg  [7:0] sr_cnt_reg;
wire       sr_last = ({1'b0, sr_cnt_reg} + 9'h001) == {1'b0, sr_tgt};
wire       ev_rssi = ~crit_sr & rssi_hit[chan_sel] & ~hit_prev_reg;
wire       ev_sr   = crit_sr & t16_strobe & sig_rec & sr_last;
wire       ev      = ev_rssi | ev_sr;

always @(posedge mclk)
begin
    if (rst)
    begin
        hit_prev_reg <= 1'b0;
        sr_cnt_reg   <= 8'h00;
    end
    else
    begin
        hit_prev_reg <= rssi_hit[chan_sel];
        // any low sample restarts the run
        if (t16_strobe)
        begin
            if (!sig_rec)
                sr_cnt_reg <= 8'h00;
            else if (sr_cnt_reg != 8'hff)
                sr_cnt_reg <= sr_cnt_reg + 8'h01;
        end
    end
end

// ----------------------------------------
// Level observation window
// ----------------------------------------
wire [2:0]  obs_ps   = lot_reg[`WCT_PS_HI:`WCT_PS_LO];
wire [4:0]  obs_n    = lot_reg[`WCT_CNT_HI:`WCT_CNT_LO];
wire [31:0] pre_len  = OBS_CYC << ({1'b0, obs_ps} + `WCT_PS_BASE);
wire [23:0] pre_last = pre_len[23:0] - 24'h00_0001;
wire [5:0]  obs_tgt  = (obs_n == 5'h00) ? `WCT_OBS_MAX : {1'b0, obs_n};
reg         obs_run_reg;
reg  [23:0] obs_pre_reg;
reg  [5:0]  obs_unit_reg;
wire        obs_tick = obs_run_reg && (obs_pre_reg == pre_last);
wire        obs_end  = obs_tick && (obs_unit_reg + 6'h01 == obs_tgt);

// count x factor x base cycles
always @(posedge mclk)
begin
    if (rst)
    begin
        obs_run_reg  <= 1'b0;
        obs_pre_reg  <= 24'h00_0000;
        obs_unit_reg <= 6'h00;
    end
    else if (obs_start)
    begin
        obs_run_reg  <= 1'b1;
        obs_pre_reg  <= 24'h00_0000;
        obs_unit_reg <= 6'h00;
    end
    else if (obs_run_reg)
    begin
        if (obs_end)
            obs_run_reg <= 1'b0;
        if (obs_tick)
        begin
            obs_pre_reg  <= 24'h00_0000;
            obs_unit_reg <= obs_unit_reg + 6'h01;
        end
        else
            obs_pre_reg <= obs_pre_reg + 24'h00_0001;
    end
end

// ----------------------------------------
// Synchronization search timeout
// ----------------------------------------
reg        src_run_reg;
reg  [7:0] src_cnt_reg;
wire       src_end  = src_run_reg & t16_strobe &
                      (src_cnt_reg + 8'h01 == src_reg);
// zero means no search time at all
wire       src_zero = search_start & (src_reg == 8'h00);

always @(posedge mclk)
begin
    if (rst)
    begin
        src_run_reg <= 1'b0;
        src_cnt_reg <= 8'h00;
    end
    else if (search_start)
    begin
        src_run_reg <= (src_reg != 8'h00);
        src_cnt_reg <= 8'h00;
    end
    else if (sync_found | src_end)
        src_run_reg <= 1'b0;
    else if (src_run_reg & t16_strobe)
        src_cnt_reg <= src_cnt_reg + 8'h01;
end

// ----------------------------------------
// Symbol synchronization loss timeout
// ----------------------------------------
localparam [23:0] SYNC_LAST = SYNC_CYC - 1;
reg        tos_run_reg;
reg  [23:0] tos_pre_reg;
reg  [7:0] tos_unit_reg;
wire       tos_tick = tos_run_reg && (tos_pre_reg == SYNC_LAST);
wire       tos_end  = tos_tick && (tos_unit_reg + 8'h01 == tos_reg);

always @(posedge mclk)
begin
    if (rst)
    begin
        tos_run_reg  <= 1'b0;
        tos_pre_reg  <= 24'h00_0000;
        tos_unit_reg <= 8'h00;
    end
    else if (cycle_start & rmsp_active)
    begin
        tos_run_reg  <= (tos_reg != 8'h00);
        tos_pre_reg  <= 24'h00_0000;
        tos_unit_reg <= 8'h00;
    end
    // sync found or mode left stops it
    else if (~rmsp_active | sync_found | tos_end)
        tos_run_reg <= 1'b0;
    // value x 64 x 512 cycles
    else if (tos_tick)
    begin
        tos_pre_reg  <= 24'h00_0000;
        tos_unit_reg <= tos_unit_reg + 8'h01;
    end
    else if (tos_run_reg)
        tos_pre_reg <= tos_pre_reg + 24'h00_0001;
end

// ----------------------------------------
// Event outputs and peak saturation
// ----------------------------------------
always @(posedge mclk)
begin
    if (rst)
    begin
        wake_up          <= 1'b0;
        fallback_event   <= 1'b0;
        obs_done         <= 1'b0;
        search_expired   <= 1'b0;
        return_self_poll <= 1'b0;
        peak_sat         <= 8'h00;
    end
    else
    begin
        wake_up          <= ev & ~ctrl_reg[`WCT_CTRL_FB];
        fallback_event   <= ev & ctrl_reg[`WCT_CTRL_FB];
        obs_done         <= obs_end;
        search_expired   <= src_end | src_zero;
        return_self_poll <= tos_end & rmsp_active;
        peak_sat         <= (peak_in > sat_reg) ? sat_reg : peak_in;
    end
end

// ----------------------------------------
// Interrupt status and output
// ----------------------------------------
wire [4:0] ev_vec  = {return_self_poll, search_expired, obs_done,
                      fallback_event, wake_up};
wire [4:0] clr_vec = (wr_en && idx == `WCT_IDX_STAT) ? wdat[4:0] : 5'h00;
// A new event beats a same-cycle write-one-to-clear
wire [4:0] stat_next = (stat_reg & ~clr_vec) | ev_vec;

always @(posedge mclk)
begin
    if (rst)
    begin
        stat_reg <= `WCT_RST_STAT;
        irq      <= 1'b0;
    end
    else
    begin
        stat_reg <= stat_next;
        irq      <= |(stat_next & mask_reg);
    end
end

endmodule // wct_top

// ===== hdl/wct_defines.vh
// Register indices, field positions, reset values and timing counts
`ifndef WCT_DEFINES_VH
`define WCT_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define WCT_IDX_TH2     8'h1e
`define WCT_IDX_BL2     8'h1f
`define WCT_IDX_BH2     8'h20
`define WCT_IDX_TH3     8'h21
`define WCT_IDX_BL3     8'h22
`define WCT_IDX_BH3     8'h23
`define WCT_IDX_SAT     8'h24
`define WCT_IDX_LOT     8'h25
`define WCT_IDX_SRC     8'h26
`define WCT_IDX_TOS     8'h27
`define WCT_IDX_STAT    8'h30
`define WCT_IDX_MASK    8'h31
`define WCT_IDX_CTRL    8'h32

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WCT_RST_TH      8'h00
`define WCT_RST_BL      8'hff
`define WCT_RST_BH      8'h00
`define WCT_RST_SAT     8'h10
`define WCT_RST_LOT     8'h00
`define WCT_RST_SRC     8'h87
`define WCT_RST_TOS     8'hff
`define WCT_RST_STAT    5'h00
`define WCT_RST_MASK    5'h00
`define WCT_RST_CTRL    3'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WCT_PS_HI       7
`define WCT_PS_LO       5
`define WCT_CNT_HI      4
`define WCT_CNT_LO      0
`define WCT_CTRL_FB     2

// ----------------------------------------
// Base timing counts in mclk periods, prescaler shift base and observation unit limit
// ----------------------------------------
`define WCT_OBS_CYC     64
`define WCT_SYNC_CYC    32768
`define WCT_PS_BASE     4'h2
`define WCT_OBS_MAX     6'h20

`endif

// ===== test/wct_top_sva.sv
// Port checker for the wake-up criteria bank
`timescale 1ns/1ps
`include "wct_defines.vh"
module wct_top_sva #(
    parameter OBS_CYC  = `WCT_OBS_CYC,
    parameter SYNC_CYC = `WCT_SYNC_CYC
) (
    input wire       mclk,
    input wire       rst,
    input wire       wake_up,
    input wire       fallback_event,
    input wire [7:0] peak_in,
    input wire [7:0] peak_sat,
    input wire       obs_start,
    input wire       obs_done,
    input wire       search_expired,
    input wire       cycle_start,
    input wire       rmsp_active,
    input wire       return_self_poll
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ------------------------------
    // Event outputs
    // ------------------------------
    a_wake_pulse: assert property (
        wake_up |=> !wake_up) else $error("wake_up too long");
    a_route_excl: assert property (
        !(wake_up && fallback_event)) else $error("both event outputs high");
    a_fb_pulse: assert property (
        fallback_event |=> !fallback_event) else $error("fallback_event too long");
    a_peak_limit: assert property (
        !$past(rst) |-> peak_sat <= $past(peak_in)) else $error("peak_sat above input");
    // Old window may end at the restart edge, so the first cycle is skipped
    a_obs_min: assert property (
        obs_start |=> ##1 !obs_done [*7]) else $error("window too short");
    a_obs_pulse: assert property (
        obs_done |=> !obs_done) else $error("obs_done too long");
    a_search_pulse: assert property (
        search_expired |=> !search_expired) else $error("search_expired too long");
    a_sync_mode: assert property (
        return_self_poll |-> $past(rmsp_active)) else $error("return outside run mode");
    a_sync_restart: assert property (
        cycle_start && rmsp_active |=> ##1 !return_self_poll [*2])
        else $error("timer not restarted");
    c_wake: cover property (wake_up);
    c_obs: cover property (obs_done);
    c_ret: cover property (return_self_poll);
endmodule // wct_top_sva

bind wct_top wct_top_sva #(.OBS_CYC(OBS_CYC), .SYNC_CYC(SYNC_CYC)) wct_top_sva_i (.*);

// ===== test/tb_top.sv
// Self-checking bench for the wake-up criteria bank
`timescale 1ns/1ps
module tb_top;
    localparam OC = 2;
    localparam SC = 4;
    localparam [79:0] RV = 80'hff87_0010_00ff_0000_ff00;
    localparam [31:0] LOT = 32'he15f_2001;
    reg         mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ev;
    reg         chan_sel = 0, sig_rec = 0, t16_strobe = 0, sync_found = 0, rmsp_active = 0;
    reg  [9:0]  paddr = 0;
    reg  [31:0] pwdata = 0, rv;
    reg  [7:0]  rssi_level = 0, peak_in = 0, th, bl, bh, r;
    reg  [2:0]  st = 0;
    wire [31:0] prdata;
    wire [7:0]  peak_sat;
    wire        pready, pslverr, wake_up, fallback_event, obs_done, search_expired;
    wire        return_self_poll, irq;
    wire [2:0]  ev_o = {return_self_poll, search_expired, obs_done};
    integer     n_fail = 0, checks = 0, seed = 32'h8830, t, c, nw, nf, x, k;
    integer     m [0:9];

    wct_top #(.OBS_CYC(OC), .SYNC_CYC(SC)) wct_top_i (.*, .obs_start(st[0]),
        .search_start(st[1]), .cycle_start(st[2]));

    always #5 mclk = ~mclk;

    task complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("MISMATCH %s exp %h saw %h", nm, e, s);
        end
    endtask

    // ------------------------------
    // Bus and event helpers
    // ------------------------------
    task apb(input logic w, input [7:0] i, input [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1 && k < 20);
        if (k == 20)
        begin
            n_fail++;
            complete_run;
        end
        rv = prdata;
        ev = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask

    task cnt(input integer n);
        nw = 0;
        nf = 0;
        repeat (n)
        begin
            @(posedge mclk);
            nw += wake_up === 1;
            nf += fallback_event === 1;
        end
    endtask

    // Edges counted from the one that samples the start pulse
    task meas(input integer w);
        st[w] <= 1;
        c = 0;
        do
        begin
            @(posedge mclk);
            st <= 0;
            c++;
        end
        while (ev_o[w] !== 1 && c < 3000);
    endtask

    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        for (t = 0; t < 10; t++)
        begin
            apb(0, 8'h1e + t, 0);
            chk("reset", rv, RV[8*t +: 8]);
            m[t] = $random(seed) & 8'hff;
            apb(1, 8'h1e + t, m[t]);
            apb(0, 8'h1e + t, 0);
            chk("readback", rv, m[t]);
        end
        apb(0, 8'h10, 0);
        chk("unmapped", ev, 1);
        for (t = 0; t < 8; t++)
        begin
            peak_in <= $random(seed);
            repeat (2) @(posedge mclk);
            chk("peak", peak_sat, peak_in < m[6] ? peak_in : m[6]);
        end
        // Bias the limits so that hits and blocks both occur
        for (t = 0; t < 24; t++)
        begin
            th = $random(seed) & 8'h7f;
            bl = $random(seed) | 8'h80;
            bh = $random(seed) & 8'h3f;
            r = $random(seed);
            x = t[0] ? 8'h21 : 8'h1e;
            apb(1, x, th);
            apb(1, x + 1, bl);
            apb(1, x + 2, bh);
            apb(1, 8'h32, t[1] << 2);
            chan_sel <= t[0];
            rssi_level <= 0;
            cnt(3);
            rssi_level <= r;
            cnt(5);
            x = r > th && r <= bl && r >= bh;
            chk("wake", nw, x && !t[1]);
            chk("fallback", nf, x && t[1]);
        end
        apb(1, 8'h32, 2);
        apb(1, 8'h23, 3);
        chan_sel <= 1;
        t16_strobe <= 1;
        nw = 0;
        for (t = 0; t < 10; t++)
        begin
            sig_rec <= t < 7 ? 7'b1111011 >> t : 0;
            @(posedge mclk);
            nw += wake_up === 1;
            if (t == 5)
                chk("sig_early", nw, 0);
        end
        chk("sig_once", nw, 1);
        for (t = 0; t < 4; t++)
        begin
            x = LOT[8*t +: 8];
            apb(1, 8'h25, x);
            meas(0);
            chk("obs", c, ((x & 31) ? x & 31 : 32) * (4 << (x >> 5)) * OC + 2);
        end
        apb(1, 8'h26, 0);
        meas(1);
        chk("search0", c, 2);
        apb(1, 8'h26, 4);
        meas(1);
        chk("search4", c, 6);
        t16_strobe <= 0;
        apb(1, 8'h30, 32'h1f);
        apb(1, 8'h31, 32'h10);
        rmsp_active <= 1;
        for (t = 1; t < 4; t += 2)
        begin
            apb(1, 8'h27, t);
            meas(2);
            chk("sync", c, t * SC + 2);
        end
        repeat (2) @(posedge mclk);
        chk("irq", irq, 1);
        apb(0, 8'h30, 0);
        chk("status", rv, 32'h10);
        apb(1, 8'h30, 32'h10);
        chk("irq_clear", irq, 0);
        apb(1, 8'h31, 0);
        st[2] <= 1;
        @(posedge mclk);
        st <= 0;
        @(posedge mclk);
        meas(2);
        chk("restart", c, 3 * SC + 2);
        repeat (2) @(posedge mclk);
        chk("irq_masked", irq, 0);
        apb(1, 8'h27, 0);
        meas(2);
        chk("sync_off", c, 3000);
        complete_run;
    end
endmodule // tb_top
